// ===== pn_corr_regs.svh
`ifndef PN_CORR_REGS_SVH
`define PN_CORR_REGS_SVH

// Register indices; byte address is four times the index
`define IDX_PRE_COEF    6'h07
`define IDX_PRE_COEF_END 6'h16
`define IDX_DATA_COEF   6'h17
`define IDX_DATA_COEF_END 6'h26
`define IDX_AVG_CTRL    6'h27
`define IDX_VIEWPORT    6'h28
`define IDX_PRE_THR_LO  6'h29
`define IDX_PRE_THR_HI  6'h2A
`define IDX_DATA_THR_LO 6'h2B
`define IDX_DATA_THR_HI 6'h2C
`define IDX_CHIPS       6'h2D
`define IDX_BLEN_LO     6'h2E
`define IDX_MISS_LIM    6'h2F
`define IDX_BURST_CTRL  6'h30
`define IDX_TAP_PWR     6'h39
`define IDX_BLEN_HI     6'h3A
`define IDX_STATUS      6'h3B
`define IDX_MISS_CNT    6'h3C

// Field positions
`define AVG_BYPASS_BIT  0
`define BC_ABORT_EN_BIT 0
`define BC_MAXSEL_DIS_BIT 3
`define BC_LEN_DIS_BIT  6
`define TAP_GROUPS      7
`define TAPS_PER_GROUP  7

// Coefficient codes
`define COEF_PLUS       2'h1
`define COEF_MINUS      2'h3

// Reset values
`define RST_BYTE        8'h00
`define RST_CHIPS       8'h40
`define RST_THR_LO      8'hFF
`define RST_THR_HI      8'h03

// Timing counts in baseband samples
`define FLY_WIN         11'h001
`define SEL_LAT         11'h003

`endif

// ===== pn_corr_pkg.sv
package pn_corr_pkg;
  // Receiver operating mode
  typedef enum logic {MODE_ACQ, MODE_TRACK} rx_mode_t;
  // Averaged 3-bit offset sample
  typedef logic signed [2:0] samp_t;
  // Signed tap product
  typedef logic signed [3:0] prod_t;
  // Raw correlator output
  typedef logic signed [9:0] corr_t;
  // Viewport output
  typedef logic signed [7:0] view_t;
  // Power estimate
  typedef logic [9:0] pwr_t;
endpackage : pn_corr_pkg

// ===== pn_correlator_symbol_tracker.sv
// Functional notes
// [RULE1] Separate preamble and data codes, 64 chips
// [RULE2] Ternary 2-bit taps; zero end taps shorten
// [RULE3] Seven-tap groups powered down by bits 6-0
// [RULE4] Tap 0 first in line, 63 last
// [RULE5] Burst starts in acquisition with preamble set
// [RULE6] Preamble detect switches to data set
// [RULE7] Averager sums sample pairs, unbiased 3-bit rounding
// [RULE8] Averager control bit 0 bypasses averager
// [RULE9] 64-tap correlation sum every baseband sample
// [RULE10] Shared saturating viewport makes 8-bit outputs
// [RULE11] Power is max plus half min
// [RULE12] Symbol pulse when power exceeds threshold
// [RULE13] Threshold chosen by acquisition or data mode
// [RULE14] Flywheel accepts detects within one sample window
// [RULE15] Missing detect inserted one symbol after last
// [RULE16] Max selector picks peak of three
// [RULE17] Missed detects counted; optional abort to acquisition
// [RULE18] Burst length reached returns to acquisition
// [RULE19] Burst control bit 6 disables length return
// [RULE20] Upstream gives 3-bit samples, two per chip
// [RULE21] Return to acquisition clears counters and timing
`timescale 1ns/100ps
`default_nettype none
`include "pn_corr_regs.svh"

module pn_correlator_symbol_tracker #(
  parameter int TAPS = 64
) (
  // APB clock and reset
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  // APB slave
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [7:0]           paddr,
  input  wire logic [31:0]          pwdata,
  output var  logic [31:0]          prdata,
  output var  logic                 pready,
  output var  logic                 pslverr,
  // Baseband samples from the integrate-and-dump stage
  input  wire logic                 samp_valid,
  input  wire pn_corr_pkg::samp_t   samp_i,
  input  wire pn_corr_pkg::samp_t   samp_q,
  // Despread outputs
  output var  logic                 desp_valid,
  output var  pn_corr_pkg::view_t   desp_i,
  output var  pn_corr_pkg::view_t   desp_q,
  output var  pn_corr_pkg::pwr_t    power,
  // Symbol timing
  output var  logic                 sym_pulse,
  output var  logic                 acq_mode
);
  import pn_corr_pkg::*;

  // Writable register indices
  function automatic logic is_rw(input logic [5:0] idx);
    is_rw = (idx >= `IDX_PRE_COEF && idx <= `IDX_BURST_CTRL) ||
            idx == `IDX_TAP_PWR || idx == `IDX_BLEN_HI;
  endfunction : is_rw

  // Shift right by sel, saturate to 8 bits
  function automatic view_t viewport(input corr_t x, input logic [1:0] sel);
    corr_t s;
    s = x >>> sel;
    if (s > 10'sd127)       viewport = 8'sh7F;
    else if (s < -10'sd128) viewport = 8'sh80;
    else                    viewport = s[7:0];
  endfunction : viewport

  // Absolute value of a viewport output
  function automatic logic [7:0] absval(input view_t x);
    absval = x[7] ? 8'(-x) : 8'(x);
  endfunction : absval

  // ---------------- Register file ----------------
  logic [7:0]  cfg_reg  [0:63];        // Byte registers by index
  logic [7:0]  cfg_next [0:63];        // Next register values
  logic [31:0] prdata_reg, prdata_next; // Read data
  logic        pready_reg, pready_next; // Access-phase ready
  logic        pslverr_reg, pslverr_next; // Error answer
  logic [5:0]  idx;                    // Word index of paddr
  logic [7:0]  miss_reg;               // Missed detects in burst
  logic        acq_reg;                // Acquisition flag
  logic [7:0]  rd_byte;                // Selected read byte

  assign idx = paddr[7:2];

  // Bus decode, write and read mux
  always_comb begin
    for (int k = 0; k < 64; k++) begin
      cfg_next[k] = cfg_reg[k];
    end
    rd_byte = 8'h00;
    if (is_rw(idx))                rd_byte = cfg_reg[idx];
    else if (idx == `IDX_STATUS)   rd_byte = {7'h00, acq_reg};
    else if (idx == `IDX_MISS_CNT) rd_byte = miss_reg;
    // Answer prepared in setup
    pready_next  = psel && !penable;
    prdata_next  = {24'h000000, rd_byte};
    pslverr_next = (paddr[1:0] != 2'h0) ||
                   !(is_rw(idx) || idx == `IDX_STATUS || idx == `IDX_MISS_CNT);
    if (psel && penable && pready_reg && pwrite && !pslverr_reg && is_rw(idx)) begin
      cfg_next[idx] = pwdata[7:0];
    end
  end

  // Register file flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int k = 0; k < 64; k++) begin
        cfg_reg[k] <= `RST_BYTE;
      end
      cfg_reg[`IDX_CHIPS]       <= `RST_CHIPS;
      cfg_reg[`IDX_PRE_THR_LO]  <= `RST_THR_LO;
      cfg_reg[`IDX_PRE_THR_HI]  <= `RST_THR_HI;
      cfg_reg[`IDX_DATA_THR_LO] <= `RST_THR_LO;
      cfg_reg[`IDX_DATA_THR_HI] <= `RST_THR_HI;
      prdata_reg  <= 32'h00000000;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      for (int k = 0; k < 64; k++) begin
        cfg_reg[k] <= cfg_next[k];
      end
      prdata_reg  <= prdata_next;
      pready_reg  <= pready_next;
      pslverr_reg <= pslverr_next;
    end
  end

  // Configuration fields
  logic        avg_bypass;  // Averager bypass
  logic [1:0]  view_sel;    // Viewport select
  logic [9:0]  thr;         // Threshold in use
  logic [10:0] sym_len;     // Samples per symbol
  logic [15:0] burst_len;   // Symbols per burst
  logic        abort_en;    // Missed-detect abort enable
  logic        maxsel_dis;  // Max selector disable
  logic        len_dis;     // Burst length return disable
  logic [6:0]  tap_pwr;     // Tap group power-down

  assign avg_bypass = cfg_reg[`IDX_AVG_CTRL][`AVG_BYPASS_BIT];  // RULE8
  assign view_sel   = cfg_reg[`IDX_VIEWPORT][1:0];
  assign thr        = acq_reg ?                                    // RULE13
                      {cfg_reg[`IDX_PRE_THR_HI][1:0], cfg_reg[`IDX_PRE_THR_LO]} :
                      {cfg_reg[`IDX_DATA_THR_HI][1:0], cfg_reg[`IDX_DATA_THR_LO]};
  assign sym_len    = {2'b00, cfg_reg[`IDX_CHIPS], 1'b0};
  assign burst_len  = {cfg_reg[`IDX_BLEN_HI], cfg_reg[`IDX_BLEN_LO]};
  assign abort_en   = cfg_reg[`IDX_BURST_CTRL][`BC_ABORT_EN_BIT];
  assign maxsel_dis = cfg_reg[`IDX_BURST_CTRL][`BC_MAXSEL_DIS_BIT];
  assign len_dis    = cfg_reg[`IDX_BURST_CTRL][`BC_LEN_DIS_BIT];
  assign tap_pwr    = cfg_reg[`IDX_TAP_PWR][6:0];

  // ---------------- Front-end averager ----------------
  samp_t prev_i_reg, prev_i_next;  // Previous raw I sample
  samp_t prev_q_reg, prev_q_next;  // Previous raw Q sample
  samp_t avg_i_reg, avg_i_next;    // Averaged I
  samp_t avg_q_reg, avg_q_next;    // Averaged Q
  logic  avg_v_reg, avg_v_next;    // Averaged sample valid
  logic  rtog_reg, rtog_next;      // Rounding direction toggle

  // Sum of two offset samples
  always_comb begin
    logic signed [3:0] si;
    logic signed [3:0] sq;
    si = 4'(samp_i) + 4'(prev_i_reg);
    sq = 4'(samp_q) + 4'(prev_q_reg);
    prev_i_next = prev_i_reg;
    prev_q_next = prev_q_reg;
    avg_i_next  = avg_i_reg;
    avg_q_next  = avg_q_reg;
    rtog_next   = rtog_reg;
    avg_v_next  = samp_valid;
    if (samp_valid) begin                                 // RULE20
      prev_i_next = samp_i;
      prev_q_next = samp_q;
      if (avg_bypass) begin                               // RULE8
        avg_i_next = samp_i;
        avg_q_next = samp_q;
      end else begin
        // Toggle rounds odd sums without bias
        avg_i_next = 3'((si + 4'(si[0] & rtog_reg)) >>> 1);   // RULE7
        avg_q_next = 3'((sq + 4'(sq[0] & rtog_reg)) >>> 1);   // RULE7
        rtog_next  = rtog_reg ^ si[0] ^ sq[0];
      end
    end
  end

  // Averager flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_i_reg <= 3'sh0;
      prev_q_reg <= 3'sh0;
      avg_i_reg  <= 3'sh0;
      avg_q_reg  <= 3'sh0;
      avg_v_reg  <= 1'b0;
      rtog_reg   <= 1'b0;
    end else begin
      prev_i_reg <= prev_i_next;
      prev_q_reg <= prev_q_next;
      avg_i_reg  <= avg_i_next;
      avg_q_reg  <= avg_q_next;
      avg_v_reg  <= avg_v_next;
      rtog_reg   <= rtog_next;
    end
  end

  // ---------------- Matched filter ----------------
  samp_t dl_i_reg [0:TAPS-1];  // I delay line, tap 0 newest
  samp_t dl_q_reg [0:TAPS-1];  // Q delay line
  prod_t prod_i   [0:TAPS-1];  // I tap products
  prod_t prod_q   [0:TAPS-1];  // Q tap products

  // Delay lines and per-tap multipliers
  genvar t;
  generate
    for (t = 0; t < TAPS; t++) begin : g_tap
      logic [7:0]  cbyte;  // Coefficient byte for this tap
      logic [1:0]  coef;   // Ternary coefficient
      logic        off;    // Tap group powered down
      prod_t       vi;     // Offset I value times two
      prod_t       vq;     // Offset Q value times two
      assign cbyte = acq_reg ? cfg_reg[`IDX_PRE_COEF + 6'(t / 4)]      // RULE5
                             : cfg_reg[`IDX_DATA_COEF + 6'(t / 4)];    // RULE6 RULE1
      assign coef  = cbyte[2 * (t % 4) +: 2];                          // RULE2
      assign off   = (t / `TAPS_PER_GROUP < `TAP_GROUPS) &&
                     tap_pwr[t / `TAPS_PER_GROUP];                     // RULE3
      assign vi    = {dl_i_reg[t], 1'b1};
      assign vq    = {dl_q_reg[t], 1'b1};
      assign prod_i[t] = (off || coef == 2'h0 || coef == 2'h2) ? 4'sh0 :
                         (coef == `COEF_PLUS) ? vi : 4'(-vi);          // RULE2
      assign prod_q[t] = (off || coef == 2'h0 || coef == 2'h2) ? 4'sh0 :
                         (coef == `COEF_PLUS) ? vq : 4'(-vq);
      // Sample enters at tap 0
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          dl_i_reg[t] <= 3'sh0;
          dl_q_reg[t] <= 3'sh0;
        end else if (avg_v_reg) begin                                  // RULE4
          dl_i_reg[t] <= (t == 0) ? avg_i_reg : dl_i_reg[(t == 0) ? 0 : t - 1];
          dl_q_reg[t] <= (t == 0) ? avg_q_reg : dl_q_reg[(t == 0) ? 0 : t - 1];
        end
      end
    end
  endgenerate

  corr_t corr_i_reg, corr_i_next;  // I correlation
  corr_t corr_q_reg, corr_q_next;  // Q correlation
  logic  corr_v_reg, corr_v_next;  // Correlation valid

  // Adder trees
  always_comb begin
    corr_t si;
    corr_t sq;
    si = 10'sh000;
    sq = 10'sh000;
    for (int k = 0; k < TAPS; k++) begin
      si = si + 10'(prod_i[k]);                                        // RULE9
      sq = sq + 10'(prod_q[k]);
    end
    corr_v_next = avg_v_reg;
    corr_i_next = avg_v_reg ? si : corr_i_reg;
    corr_q_next = avg_v_reg ? sq : corr_q_reg;
  end

  // Correlator output flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      corr_i_reg <= 10'sh000;
      corr_q_reg <= 10'sh000;
      corr_v_reg <= 1'b0;
    end else begin
      corr_i_reg <= corr_i_next;
      corr_q_reg <= corr_q_next;
      corr_v_reg <= corr_v_next;
    end
  end

  // ---------------- Viewport and power ----------------
  view_t vw_i_reg, vw_i_next;  // Despread I
  view_t vw_q_reg, vw_q_next;  // Despread Q
  pwr_t  pwr_reg, pwr_next;    // Power estimate
  logic  pv_reg, pv_next;      // Power valid

  // Shared viewport then max plus half min
  always_comb begin
    view_t      a;
    view_t      b;
    logic [7:0] ma;
    logic [7:0] mb;
    a  = viewport(corr_i_reg, view_sel);                               // RULE10
    b  = viewport(corr_q_reg, view_sel);                               // RULE10
    ma = absval(a);
    mb = absval(b);
    pv_next   = corr_v_reg;
    vw_i_next = corr_v_reg ? a : vw_i_reg;
    vw_q_next = corr_v_reg ? b : vw_q_reg;
    pwr_next  = pwr_reg;
    if (corr_v_reg) begin
      pwr_next = (ma > mb) ? 10'(ma) + 10'(mb >> 1) : 10'(mb) + 10'(ma >> 1); // RULE11
    end
  end

  // Viewport and power flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vw_i_reg <= 8'sh00;
      vw_q_reg <= 8'sh00;
      pwr_reg  <= 10'h000;
      pv_reg   <= 1'b0;
    end else begin
      vw_i_reg <= vw_i_next;
      vw_q_reg <= vw_q_next;
      pwr_reg  <= pwr_next;
      pv_reg   <= pv_next;
    end
  end

  // ---------------- Symbol tracker ----------------
  rx_mode_t    mode_reg, mode_next;    // Acquisition or tracking
  logic [10:0] tcnt_reg, tcnt_next;    // Samples since last valid symbol
  logic [1:0]  run_reg, run_next;      // Length of current over-threshold run
  pwr_t        peak_reg, peak_next;    // Largest power in run
  logic [1:0]  age_reg, age_next;      // Samples since that peak
  logic [15:0] symcnt_reg, symcnt_next; // Symbols in burst
  logic [7:0]  miss_next;              // Next missed count
  logic        acq_next;               // Next acquisition flag
  logic        pulse_reg, pulse_next;  // Symbol clock pulse

  // Detection, flywheel and burst counts
  always_comb begin
    logic        exceed;
    logic        det;
    logic [1:0]  dage;
    logic [10:0] now;
    logic [10:0] pk;
    logic        sym;
    logic        leave;
    exceed = pwr_reg > thr;                                            // RULE12
    det    = 1'b0;
    dage   = 2'h0;
    now    = tcnt_reg + 11'h001;
    sym    = 1'b0;
    leave  = 1'b0;
    pk     = 11'h000;
    mode_next   = mode_reg;
    tcnt_next   = tcnt_reg;
    run_next    = run_reg;
    peak_next   = peak_reg;
    age_next    = age_reg;
    symcnt_next = symcnt_reg;
    miss_next   = miss_reg;
    if (pv_reg) begin
      tcnt_next = now;
      // Max of up to three adjacent samples
      if (maxsel_dis) begin
        det = exceed;                                                  // RULE16
      end else if (exceed) begin
        run_next  = run_reg + 2'h1;
        peak_next = (run_reg == 2'h0 || pwr_reg > peak_reg) ? pwr_reg : peak_reg;
        age_next  = (run_reg == 2'h0 || pwr_reg > peak_reg) ? 2'h0 : age_reg + 2'h1;
        if (run_reg == 2'h2) begin                                     // RULE16
          det      = 1'b1;
          dage     = age_next;
          run_next = 2'h0;
        end
      end else if (run_reg != 2'h0) begin
        det      = 1'b1;
        dage     = age_reg + 2'h1;
        run_next = 2'h0;
      end
      pk = now - 11'(dage);
      case (mode_reg)
        MODE_ACQ: begin
          if (det) begin                                               // RULE6
            mode_next   = MODE_TRACK;
            tcnt_next   = 11'(dage);
            sym         = 1'b1;
            symcnt_next = 16'h0000;
            miss_next   = 8'h00;
          end
        end
        MODE_TRACK: begin
          if (det && pk + `FLY_WIN >= sym_len && pk <= sym_len + `FLY_WIN) begin // RULE14
            tcnt_next   = 11'(dage);
            sym         = 1'b1;
            symcnt_next = symcnt_reg + 16'h0001;
          end else if (now == sym_len + `FLY_WIN + `SEL_LAT) begin
            // Inserted pulse keeps the nominal grid
            tcnt_next   = now - sym_len;                               // RULE15
            sym         = 1'b1;
            symcnt_next = symcnt_reg + 16'h0001;
            miss_next   = miss_reg + 8'h01;                            // RULE17
            leave       = abort_en && miss_next > cfg_reg[`IDX_MISS_LIM]; // RULE17
          end
          if (sym && !len_dis && symcnt_next == burst_len) begin       // RULE18 RULE19
            leave = 1'b1;
          end
          if (leave) begin                                             // RULE21
            mode_next   = MODE_ACQ;
            tcnt_next   = 11'h000;
            run_next    = 2'h0;
            symcnt_next = 16'h0000;
            miss_next   = 8'h00;
          end
        end
        default: begin
          mode_next = MODE_ACQ;
        end
      endcase
    end
    pulse_next = sym;
    acq_next   = (mode_next == MODE_ACQ);                              // RULE5
  end

  // Tracker flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_reg   <= MODE_ACQ;
      tcnt_reg   <= 11'h000;
      run_reg    <= 2'h0;
      peak_reg   <= 10'h000;
      age_reg    <= 2'h0;
      symcnt_reg <= 16'h0000;
      miss_reg   <= 8'h00;
      acq_reg    <= 1'b1;
      pulse_reg  <= 1'b0;
    end else begin
      mode_reg   <= mode_next;
      tcnt_reg   <= tcnt_next;
      run_reg    <= run_next;
      peak_reg   <= peak_next;
      age_reg    <= age_next;
      symcnt_reg <= symcnt_next;
      miss_reg   <= miss_next;
      acq_reg    <= acq_next;
      pulse_reg  <= pulse_next;
    end
  end

  // Outputs straight from flops
  assign prdata     = prdata_reg;
  assign pready     = pready_reg;
  assign pslverr    = pslverr_reg;
  assign desp_valid = pv_reg;
  assign desp_i     = vw_i_reg;
  assign desp_q     = vw_q_reg;
  assign power      = pwr_reg;
  assign sym_pulse  = pulse_reg;
  assign acq_mode   = acq_reg;

endmodule : pn_correlator_symbol_tracker
`default_nettype wire

// ===== pn_corr_chk.sv
`timescale 1ns/100ps
`default_nettype none
// Checks bus handshake and datapath timing
module pn_corr_chk (
  // Clock and reset
  input wire logic               pclk,
  input wire logic               presetn,
  // Register bus
  input wire logic               psel,
  input wire logic               penable,
  input wire logic [7:0]         paddr,
  input wire logic [31:0]        prdata,
  input wire logic               pready,
  input wire logic               pslverr,
  // Datapath
  input wire logic               samp_valid,
  input wire logic               desp_valid,
  input wire pn_corr_pkg::view_t desp_i,
  input wire pn_corr_pkg::view_t desp_q,
  input wire pn_corr_pkg::pwr_t  power,
  input wire logic               sym_pulse,
  input wire logic               acq_mode
);
  import pn_corr_pkg::*;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Larger magnitude plus half the smaller
  function automatic pwr_t mag(input view_t a, input view_t b);
    logic [8:0] x;
    logic [8:0] y;
    x = a[7] ? -{a[7], a} : {1'b0, a};
    y = b[7] ? -{b[7], b} : {1'b0, b};
    return (x > y) ? 10'(x) + 10'(y >> 1) : 10'(y) + 10'(x >> 1);
  endfunction : mag
  // Bus phases
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence access_s;
    psel && penable && pready;
  endsequence
  AST_PREADY_ACCESS: assert property (setup_s |=> access_s)
    else $error("no ready in access phase");
  AST_PREADY_ONLY: assert property (pready |-> psel && penable)
    else $error("ready outside access phase");
  AST_SLVERR_ALIGN: assert property (psel && !penable && paddr[1:0] != 2'h0 |=> pslverr)
    else $error("misaligned access not refused");
  AST_PRDATA_HI: assert property (pready |-> prdata[31:8] == 24'h000000)
    else $error("upper read data not zero");
  AST_DESP_LAT: assert property (samp_valid |-> ##3 desp_valid)
    else $error("despread output late or missing");
  AST_DESP_CAUSE: assert property (desp_valid |-> $past(samp_valid, 3))
    else $error("despread output without sample");
  AST_POWER: assert property (desp_valid |-> power == mag(desp_i, desp_q))
    else $error("power estimate wrong");
  AST_VIEW_HOLD: assert property (!desp_valid |-> $stable(desp_i) && $stable(desp_q))
    else $error("despread output moved between samples");
  AST_SYM_SINGLE: assert property (sym_pulse |=> !sym_pulse)
    else $error("symbol pulse longer than one cycle");
  AST_ACQ_EXIT: assert property ($fell(acq_mode) |-> sym_pulse || $past(sym_pulse))
    else $error("acquisition left without detect");
endmodule : pn_corr_chk

bind pn_correlator_symbol_tracker pn_corr_chk u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .samp_valid(samp_valid),
  .desp_valid(desp_valid), .desp_i(desp_i), .desp_q(desp_q), .power(power),
  .sym_pulse(sym_pulse), .acq_mode(acq_mode)
);
`default_nettype wire

// ===== pn_corr_src.sv
`timescale 1ns/100ps
`default_nettype none
// Upstream stand-in: one sample every other clock
module pn_corr_src (
  // Clock and reset
  input  wire logic               pclk,
  input  wire logic               presetn,
  // Stimulus shape
  input  wire logic               noise,
  input  wire logic               imp_en,
  input  wire logic [7:0]         period,
  input  wire pn_corr_pkg::samp_t lvl_i,
  input  wire pn_corr_pkg::samp_t lvl_q,
  // Samples toward the correlator
  output var  logic               samp_valid,
  output var  pn_corr_pkg::samp_t samp_i,
  output var  pn_corr_pkg::samp_t samp_q
);
  import pn_corr_pkg::*;
  logic       ph;  // High on the cycle that issues a sample
  logic [7:0] cnt; // Sample index within one symbol period
  // Saturated 3-bit samples at twice the chip rate
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ph         <= 1'b0;
      cnt        <= 8'h00;
      samp_valid <= 1'b0;
      samp_i     <= 3'h0;
      samp_q     <= 3'h0;
    end else begin
      ph         <= ~ph;
      samp_valid <= ph;
      if (ph) begin
        cnt <= (cnt == period - 8'h01) ? 8'h00 : cnt + 8'h01;
        if (imp_en && cnt == 8'h00) begin
          // Peak once per symbol
          samp_i <= 3'h3;
          samp_q <= 3'h3;
        end else if (noise) begin
          // Plus and minus half
          samp_i <= {3{cnt[0]}};
          samp_q <= {3{cnt[0]}};
        end else begin
          samp_i <= lvl_i;
          samp_q <= lvl_q;
        end
      end else begin
        // Invert between samples
        samp_i <= ~samp_i;
        samp_q <= ~samp_q;
      end
    end
  end
endmodule : pn_corr_src
`default_nettype wire

// ===== tb_pn_correlator_symbol_tracker.sv
`timescale 1ns/100ps
`default_nettype none
`include "pn_corr_regs.svh"
module tb_pn_correlator_symbol_tracker;
  import pn_corr_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, npl;
  logic        pready, pslverr, samp_valid, desp_valid, sym_pulse, acq_mode, noise, imp_en;
  samp_t       samp_i, samp_q, lvl_i, lvl_q;
  view_t       desp_i, desp_q;
  pwr_t        power;
  int          num_errors, cmp_count;
  // Clock, 100 ns period
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  pn_correlator_symbol_tracker DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .samp_valid(samp_valid), .samp_i(samp_i),
    .samp_q(samp_q), .desp_valid(desp_valid), .desp_i(desp_i), .desp_q(desp_q),
    .power(power), .sym_pulse(sym_pulse), .acq_mode(acq_mode));
  pn_corr_src u_src (.pclk(pclk), .presetn(presetn), .noise(noise), .imp_en(imp_en),
    .period(8'h08), .lvl_i(lvl_i), .lvl_q(lvl_q), .samp_valid(samp_valid),
    .samp_i(samp_i), .samp_q(samp_q));
  // Compare seen with expected
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // One APB transfer, answer taken at the pready edge
  task automatic xfer(input logic w, input logic [5:0] idx, input logic [7:0] wd);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= {idx, 2'h0};
    pwdata  <= {24'h000000, wd};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
  task automatic wr(input logic [5:0] idx, input logic [7:0] wd);
    xfer(1'b1, idx, wd);
  endtask : wr
  task automatic rdc(input string nm, input logic [5:0] idx, input logic [7:0] exp);
    xfer(1'b0, idx, 8'h00);
    chk(nm, rd, {24'h000000, exp});
  endtask : rdc
  // Bounded wait for a symbol pulse
  task automatic wait_sym;
    int n;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (sym_pulse !== 1'b1 && n < 300);
    if (n >= 300) chk("sym_pulse", 32'h0, 32'h1);
  endtask : wait_sym
  // Counts, verdict, end
  task automatic report_and_stop;
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop
  // Watchdog
  initial begin
    repeat (20000) @(posedge pclk);
    num_errors++;
    report_and_stop();
  end
  initial begin
    {presetn, psel, penable, pwrite, err, noise, imp_en} = 7'h00;
    {paddr, pwdata, rd, npl, num_errors, cmp_count} = '0;
    lvl_i = 3'h3;
    lvl_q = 3'h4;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    chk("acq_mode", {31'h0, acq_mode}, 32'h1);
    rdc("chips", `IDX_CHIPS, 8'h40);
    rdc("thr_lo", `IDX_PRE_THR_LO, 8'hFF);
    rdc("thr_hi", `IDX_DATA_THR_HI, 8'h03);
    rdc("bctrl", `IDX_BURST_CTRL, 8'h00);
    xfer(1'b0, 6'h31, 8'h00);
    chk("slverr", {31'h0, err}, 32'h1);
    // Constant input, tap 0 only
    wr(`IDX_PRE_COEF, `COEF_PLUS);
    repeat (20) @(posedge pclk);
    chk("desp_i", {24'h0, desp_i}, 32'h07);
    chk("desp_q", {24'h0, desp_q}, 32'hF9);
    chk("power", {22'h0, power}, 32'h0A);
    wr(`IDX_VIEWPORT, 8'h01);
    rdc("viewport", `IDX_VIEWPORT, 8'h01);
    repeat (10) @(posedge pclk);
    chk("view_i", {24'h0, desp_i}, 32'h03);
    chk("view_q", {24'h0, desp_q}, 32'hFC);
    wr(`IDX_TAP_PWR, 8'h01);
    repeat (10) @(posedge pclk);
    chk("tap_off", {24'h0, desp_i}, 32'h00);
    noise <= 1'b1;
    wr(`IDX_TAP_PWR, 8'h00);
    wr(`IDX_VIEWPORT, 8'h00);
    // Raw samples, 8-sample symbols, data tap inverted
    wr(`IDX_AVG_CTRL, 8'h01);
    wr(`IDX_CHIPS, 8'h04);
    wr(`IDX_PRE_THR_LO, 8'h05);
    wr(`IDX_PRE_THR_HI, 8'h00);
    wr(`IDX_DATA_THR_LO, 8'h05);
    wr(`IDX_DATA_THR_HI, 8'h00);
    wr(`IDX_DATA_COEF, `COEF_MINUS);
    wr(`IDX_BLEN_LO, 8'h03);
    wr(`IDX_BURST_CTRL, 8'h08);
    imp_en <= 1'b1;
    wait_sym();
    chk("pre_peak", {24'h0, desp_i}, 32'h07);
    repeat (2) @(posedge pclk);
    chk("acq_mode", {31'h0, acq_mode}, 32'h0);
    repeat (3) begin
      wait_sym();
      chk("data_peak", {24'h0, desp_i}, 32'hF9);
    end
    repeat (2) @(posedge pclk);
    chk("acq_mode", {31'h0, acq_mode}, 32'h1);
    rdc("miss_cnt", `IDX_MISS_CNT, 8'h00);
    // Length return off: tracking survives
    wr(`IDX_BURST_CTRL, 8'h48);
    repeat (5) wait_sym();
    chk("acq_mode", {31'h0, acq_mode}, 32'h0);
    // No peaks: inserted pulses are misses, then abort
    imp_en <= 1'b0;
    wr(`IDX_MISS_LIM, 8'h01);
    wr(`IDX_BURST_CTRL, 8'h49);
    wait_sym();
    rdc("miss_cnt", `IDX_MISS_CNT, 8'h01);
    wait_sym();
    repeat (2) @(posedge pclk);
    chk("acq_mode", {31'h0, acq_mode}, 32'h1);
    rdc("miss_cnt", `IDX_MISS_CNT, 8'h00);
    // Acquisition inserts nothing
    repeat (100) begin
      @(posedge pclk);
      npl = npl + {31'h0, sym_pulse};
    end
    chk("idle_pulses", npl, 32'h0);
    report_and_stop();
  end
endmodule : tb_pn_correlator_symbol_tracker
`default_nettype wire
